/* hdl/asp_top.sv */
// Accelerometer host port: serial link, hold control, modulated outputs.
// Assumes host serial clock on its own domain; processor samples arrive on the core clock.
// Command word: bit15 write, bits14:8 address, bits7:1 data, bit0 parity.
`timescale 1ns/10ps
`default_nettype none
`include "asp_defines.svh"
module asp_top
   import asp_pkg::*;
#(
   parameter int RST_HOLD_CYC = `ASP_RST_HOLD_CYC
)(
   input  wire logic        CORE_CLK_IN,
   input  wire logic        RSTN_IN,
   input  wire logic        SCLK_IN,
   input  wire logic        CS_RESET_N_IN,
   input  wire logic        DIN_IN,
   input  wire logic        CAPTURE_HOLD_N_IN,
   input  wire logic        OSC_FAULT_IN,
   input  wire logic        SAMPLE_VALID_IN,
   input  wire asp_acc_t    SAMPLE_IN,
   input  wire logic        SELFTEST_ACTIVE_IN,
   output logic             DOUT_OUT,
   output logic             DOUT_OE_OUT,
   output logic             PCM_X_OUT,
   output logic             PCM_Y_OUT,
   output logic             INT_RESET_OUT
);
   // Link domain state, clocked by the serial clock
   typedef struct packed {
      logic [15:0] rx;
      logic [15:0] tx;
      logic [4:0]  cnt;
      logic        tog;
      logic [15:0] word;
   } asp_lnk_t;

   // Falling edge state for the output pin
   typedef struct packed {
      logic dout;
   } asp_neg_t;

   // Core domain state
   typedef struct packed {
      logic [2:0]  cs_s;
      logic [1:0]  sck_s;
      logic [2:0]  tog_s;
      logic [1:0]  hold_s;
      logic [1:0]  osc_s;
      logic        hold_prev;
      logic        zero_res;
      logic        par_err;
      logic [7:0]  ctl;
      logic [7:0]  ctl_pend;
      logic        pend;
      logic [7:0]  dly;
      logic [31:0] rst_cnt;
      logic        int_rst;
      asp_acc_t    acc;
      logic [15:0] resp;
      logic [15:0] resp_l;
      logic [3:0]  pcm_div;
      logic [8:0]  pcm_ph;
      logic        pcm_x;
      logic        pcm_y;
      logic        oe;
   } asp_core_t;

   asp_lnk_t  lnk_q;
   asp_lnk_t  lnk_d;
   asp_neg_t  neg_q;
   asp_neg_t  neg_d;
   asp_core_t c_q;
   asp_core_t c_d;
   logic        lnk_rst_n;

   // Link logic is held in reset while select is high
   assign lnk_rst_n = RSTN_IN & ~CS_RESET_N_IN;

   always_comb begin
      lnk_d = lnk_q;
      lnk_d.rx = {lnk_q.rx[14:0], DIN_IN};
      lnk_d.cnt = lnk_q.cnt + 5'h01;
      if (lnk_q.cnt == 5'h0F) begin
         lnk_d.word = {lnk_q.rx[14:0], DIN_IN};
         lnk_d.tog = ~lnk_q.tog;
      end
      if (lnk_q.cnt == 5'h00) begin
         lnk_d.tx = {c_q.resp_l[14:0], 1'b0};
      end else begin
         lnk_d.tx = {lnk_q.tx[14:0], 1'b0};
      end
   end

   // Word toggle survives select release: separate register not cleared by select
   logic tog_keep_q;
   logic [15:0] word_keep_q;
   always_ff @(posedge SCLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         tog_keep_q <= 1'b0;
         word_keep_q <= 16'h0000;
      end else if (!CS_RESET_N_IN && lnk_q.cnt == 5'h0F) begin
         tog_keep_q <= ~tog_keep_q;
         word_keep_q <= {lnk_q.rx[14:0], DIN_IN};
      end
   end

   always_ff @(posedge SCLK_IN or negedge lnk_rst_n) begin
      if (!lnk_rst_n) begin
         lnk_q <= '0;
      end else begin
         lnk_q <= lnk_d;
      end
   end

   // Response word only changes while select is high, so the link reads it stable

   always_comb begin
      neg_d.dout = (lnk_q.cnt == 5'h00) ? c_q.resp_l[15] : lnk_q.tx[15];
   end

   always_ff @(negedge SCLK_IN or negedge lnk_rst_n) begin
      if (!lnk_rst_n) begin
         neg_q <= '0;
      end else begin
         neg_q <= neg_d;
      end
   end

   // Output pin: first bit presented as select falls
   logic dout_mux;
   assign dout_mux = (lnk_q.cnt == 5'h00) ? c_q.resp_l[15] : neg_q.dout;

   always_comb begin
      logic [10:0] ax;
      logic [10:0] ay;
      logic [15:0] w;
      logic [6:0]  a;
      logic [6:0]  d;
      ax = SAMPLE_IN.x;
      ay = SAMPLE_IN.y;
      w = word_keep_q;
      a = word_keep_q[14:8];
      d = word_keep_q[7:1];
      c_d = c_q;
      c_d.cs_s = {c_q.cs_s[1:0], CS_RESET_N_IN};
      c_d.sck_s = {c_q.sck_s[0], SCLK_IN};
      c_d.tog_s = {c_q.tog_s[1:0], tog_keep_q};
      c_d.hold_s = {c_q.hold_s[0], CAPTURE_HOLD_N_IN};
      c_d.osc_s = {c_q.osc_s[0], OSC_FAULT_IN};
      c_d.hold_prev = c_q.hold_s[1];
      c_d.oe = ~c_q.cs_s[1];
      // External reset: select low, clock high, held long enough
      if (!c_q.cs_s[1] && c_q.sck_s[1]) begin
         if (c_q.rst_cnt < 32'(RST_HOLD_CYC)) begin
            c_d.rst_cnt = c_q.rst_cnt + 32'h0000_0001;
         end
         if (c_q.rst_cnt >= 32'(RST_HOLD_CYC) - 32'h0000_0001) begin
            c_d.int_rst = 1'b1;
         end
      end else begin
         c_d.rst_cnt = 32'h0000_0000;
         c_d.int_rst = 1'b0;
      end
      // Self-test shift of both axes
      if (SELFTEST_ACTIVE_IN) begin
         if (c_q.ctl[`ASP_CTL_ST1_BIT]) begin
            ax = SAMPLE_IN.x - `ASP_ST_OFFSET;
            ay = SAMPLE_IN.y - `ASP_ST_OFFSET;
         end else begin
            ax = SAMPLE_IN.x + `ASP_ST_OFFSET;
            ay = SAMPLE_IN.y + `ASP_ST_OFFSET;
         end
      end
      // Result capture and hold
      if (SAMPLE_VALID_IN && !c_q.hold_s[1] && !c_q.zero_res) begin
         c_d.acc.x = ax;
         c_d.acc.y = ay;
      end
      if (c_q.hold_prev && !c_q.hold_s[1]) begin
         c_d.zero_res = 1'b0;
      end
      // Received word decode
      if (c_q.tog_s[2] != c_q.tog_s[1]) begin
         if (^w == 1'b0) begin
            c_d.par_err = 1'b1;
         end else begin
            c_d.par_err = 1'b0;
            if (w[15] && {1'b0, a} == `ASP_ADDR_CTL) begin
               c_d.ctl_pend = {1'b0, d} & `ASP_CTL_RW_MASK;
            end
            c_d.resp = 16'h0000;
            unique case ({1'b0, a})
               `ASP_ADDR_CTL:    c_d.resp[15:8] = c_q.ctl & `ASP_CTL_RW_MASK;
               `ASP_ADDR_ACCX_L: c_d.resp[15:8] = c_q.acc.x[7:0];
               `ASP_ADDR_ACCX_H: c_d.resp[15:8] = {5'h00, c_q.acc.x[10:8]};
               `ASP_ADDR_ACCY_L: c_d.resp[15:8] = c_q.acc.y[7:0];
               `ASP_ADDR_ACCY_H: c_d.resp[15:8] = {5'h00, c_q.acc.y[10:8]};
               default:          c_d.resp[15:8] = 8'h00;
            endcase
         end
      end
      // Control write applied a fixed delay after select rises
      if (c_q.cs_s[2] == 1'b0 && c_q.cs_s[1] == 1'b1) begin
         c_d.pend = 1'b1;
         c_d.dly = 8'h00;
      end else if (c_q.pend) begin
         c_d.dly = c_q.dly + 8'h01;
         if (c_q.dly == 8'(`ASP_CTL_DELAY_CYC - 1)) begin
            c_d.ctl = c_q.ctl_pend;
            c_d.pend = 1'b0;
         end
      end
      // Response word latched while select idles, with odd parity
      if (c_q.cs_s[1]) begin
         if (c_q.par_err) begin
            c_d.resp_l = `ASP_EXC_WORD;
         end else begin
            c_d.resp_l = {c_q.resp[15:1], ~(^c_q.resp[15:1])};
         end
      end
      // Modulated outputs, one phase step per resolution tick
      if (c_q.pcm_div == 4'(`ASP_PCM_RES_CYC - 1)) begin
         c_d.pcm_div = 4'h0;
         c_d.pcm_ph = c_q.pcm_ph + 9'h001;
      end else begin
         c_d.pcm_div = c_q.pcm_div + 4'h1;
      end
      if (c_q.ctl[`ASP_CTL_PCM_BIT]) begin
         c_d.pcm_x = c_q.pcm_ph < c_q.acc.x[10:2];
         c_d.pcm_y = c_q.pcm_ph < c_q.acc.y[10:2];
      end else begin
         c_d.pcm_x = 1'b0;
         c_d.pcm_y = 1'b0;
      end
      if (c_q.int_rst) begin
         c_d.ctl = `ASP_CTL_RESET;
         c_d.ctl_pend = `ASP_CTL_RESET;
      end
   end

   // Strap: hold level caught once the hold synchroniser has filled
   logic [1:0] strap_q;
   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         strap_q <= 2'h0;
      end else if (strap_q != 2'h3) begin
         strap_q <= strap_q + 2'h1;
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         c_q <= '0;
         c_q.cs_s <= 3'h7;
         c_q.ctl <= `ASP_CTL_RESET;
      end else begin
         c_q <= c_d;
         if (strap_q == 2'h2 && c_q.hold_s[1]) begin
            c_q.zero_res <= 1'b1;
            c_q.acc <= '0;
         end
      end
   end

   // Pin outputs
   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         DOUT_OUT <= 1'b0;
         DOUT_OE_OUT <= 1'b0;
         PCM_X_OUT <= 1'b0;
         PCM_Y_OUT <= 1'b0;
         INT_RESET_OUT <= 1'b0;
      end else begin
         DOUT_OUT <= c_q.osc_s[1] ? 1'b1 : dout_mux;
         DOUT_OE_OUT <= c_d.oe;
         PCM_X_OUT <= c_q.pcm_x;
         PCM_Y_OUT <= c_q.pcm_y;
         INT_RESET_OUT <= c_q.int_rst;
      end
   end
endmodule
`default_nettype wire

/* hdl/asp_defines.svh */
// Constants for the accelerometer serial port, hold and modulated outputs.
// Assumes inclusion by the top module and the bench only.
// Overview of operation
// - Four-wire serial port reads the control register and acceleration.
// - Self-test shifts both axes positive when polarity bit clear, negative when set.
// - Serial clock level clocks the port and qualifies the external reset.
// - Input sampled on rising serial clock; output driven only while select low.
// - Select low with serial clock high for 512 us asserts internal reset.
// - Normal 16-bit answer word carries an odd count of one bits.
// - On oscillator fault the output stays high while select is low.
// - A word with bad parity causes an exception report in the next transfer.
// - Hold low: result registers follow every new processor sample.
// - Hold rising edge freezes results; no updates while hold stays high.
// - Hold high through reset release makes results read reserved zero.
// - Reserved zero state ends at the next falling edge of hold.
// - Modulated outputs run only while the control enable bit is set.
// - Modulation uses top nine of eleven result bits at 280 ns (7-clock) steps.
// - Control register writes take effect about 1.0 us after select rises.
// - Control register at 0x0E: enable is bit 4, self-test polarity bit 1.
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
`define ASP_CLK_MHZ        25
`define ASP_RST_HOLD_US    512
`define ASP_RST_HOLD_CYC   (`ASP_RST_HOLD_US * `ASP_CLK_MHZ)
`define ASP_CTL_DELAY_NS   1000
`define ASP_CTL_DELAY_CYC  (`ASP_CTL_DELAY_NS * `ASP_CLK_MHZ / 1000)
`define ASP_PCM_RES_NS     250
`define ASP_PCM_RES_CYC    ((`ASP_PCM_RES_NS * `ASP_CLK_MHZ + 999) / 1000)
`define ASP_ADDR_CTL       8'h0E
`define ASP_ADDR_ACCX_L    8'h24
`define ASP_ADDR_ACCX_H    8'h25
`define ASP_ADDR_ACCY_L    8'h26
`define ASP_ADDR_ACCY_H    8'h27
`define ASP_CTL_PCM_BIT    4
`define ASP_CTL_ST1_BIT    1
`define ASP_CTL_ST0_BIT    0
`define ASP_CTL_RESET      8'h00
`define ASP_CTL_RW_MASK    8'h37
`define ASP_ST_OFFSET      11'h040
`define ASP_EXC_WORD       16'h8000
`endif

/* hdl/asp_pkg.sv */
// Types for the accelerometer serial port block.
// Assumes the defines header is in the include path.
package asp_pkg;
   typedef struct packed {
      logic [10:0] x;
      logic [10:0] y;
   } asp_acc_t;

   typedef struct packed {
      logic        cmd_valid;
      logic        cmd_write;
      logic [7:0]  cmd_addr;
      logic [7:0]  cmd_data;
   } asp_cmd_t;
endpackage

/* test/asp_checker.sv */
// Pin checks for the accelerometer host port, all on the core clock.
// Assumes binding to asp_top; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module asp_checker #(
   parameter int RST_HOLD_CYC = 20
)(
   input wire logic CORE_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic SCLK_IN,
   input wire logic CS_RESET_N_IN,
   input wire logic OSC_FAULT_IN,
   input wire logic DOUT_OUT,
   input wire logic DOUT_OE_OUT,
   input wire logic PCM_X_OUT,
   input wire logic PCM_Y_OUT,
   input wire logic INT_RESET_OUT
);
   int hold_cnt_q;
   int hold_cnt_d;
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   // Cycles of select low with serial clock high
   always_comb begin
      hold_cnt_d = 0;
      if (!CS_RESET_N_IN && SCLK_IN) begin
         hold_cnt_d = (hold_cnt_q < RST_HOLD_CYC + 8) ? hold_cnt_q + 1 : hold_cnt_q;
      end
   end
   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         hold_cnt_q <= 0;
      end else begin
         hold_cnt_q <= hold_cnt_d;
      end
   end
   sequence sel_drop_s;
      $fell(CS_RESET_N_IN) ##1 !CS_RESET_N_IN;
   endsequence
   sequence fault_sel_s;
      (OSC_FAULT_IN && !CS_RESET_N_IN) [*6] ##0 DOUT_OE_OUT;
   endsequence
   oe_on_a: assert property (sel_drop_s |-> ##[0:4] DOUT_OE_OUT)
      else $error("output enable late after select fell");
   oe_off_a: assert property ($rose(CS_RESET_N_IN) |-> ##[1:5] !DOUT_OE_OUT)
      else $error("output enable late to drop");
   oe_idle_a: assert property (CS_RESET_N_IN [*6] |-> !DOUT_OE_OUT)
      else $error("output driven while deselected");
   fault_high_a: assert property (fault_sel_s |-> DOUT_OUT)
      else $error("serial output low during fault");
   reset_hold_a: assert property (hold_cnt_q == RST_HOLD_CYC + 6 |-> INT_RESET_OUT)
      else $error("no internal reset after hold");
   reset_cause_a: assert property ($rose(INT_RESET_OUT) |-> hold_cnt_q >= RST_HOLD_CYC - 2)
      else $error("internal reset without hold");
   pcm_x_step_a: assert property ($rose(PCM_X_OUT) |=> PCM_X_OUT [*6])
      else $error("x pulse shorter than one step");
   pcm_y_step_a: assert property ($rose(PCM_Y_OUT) |=> PCM_Y_OUT [*6])
      else $error("y pulse shorter than one step");
endmodule
bind asp_top asp_checker #(.RST_HOLD_CYC(RST_HOLD_CYC)) i_chk (
   .CORE_CLK_IN(CORE_CLK_IN), .RSTN_IN(RSTN_IN), .SCLK_IN(SCLK_IN),
   .CS_RESET_N_IN(CS_RESET_N_IN), .OSC_FAULT_IN(OSC_FAULT_IN),
   .DOUT_OUT(DOUT_OUT), .DOUT_OE_OUT(DOUT_OE_OUT), .PCM_X_OUT(PCM_X_OUT),
   .PCM_Y_OUT(PCM_Y_OUT), .INT_RESET_OUT(INT_RESET_OUT)
);
`default_nettype wire

/* test/asp_host_model.sv */
// Host model: serial bus master paced by a 125 ns link clock.
// Assumes one caller at a time; serial clock idles low between frames.
`timescale 1ns/10ps
`default_nettype none
module asp_host_model (
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      din_out,
   input  wire logic dout_in
);
   logic lclk = 1'b0;
   always #62.5 lclk = ~lclk;
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      din_out  = 1'b0;
   end
   function automatic logic [15:0] mk(input logic w, input logic [6:0] a, input logic [6:0] d, input logic bad);
      mk = {w, a, d, (~^{w, a, d}) ^ bad};
   endfunction
   // One word out, answer bits taken at each rising serial clock
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      @(posedge lclk);
      cs_n_out <= 1'b0;
      repeat (2) @(posedge lclk);
      for (int i = 15; i >= 0; i--) begin
         din_out <= w[i];
         repeat (2) @(posedge lclk);
         sclk_out <= 1'b1;
         r[i] = dout_in;
         repeat (2) @(posedge lclk);
         sclk_out <= 1'b0;
      end
      repeat (2) @(posedge lclk);
      cs_n_out <= 1'b1;
      din_out  <= 1'b0;
      repeat (12) @(posedge lclk);
   endtask
   task automatic hold_reset;
      @(posedge lclk);
      cs_n_out <= 1'b0;
      sclk_out <= 1'b1;
      repeat (12) @(posedge lclk);
      sclk_out <= 1'b0;
      cs_n_out <= 1'b1;
      repeat (12) @(posedge lclk);
   endtask
endmodule
`default_nettype wire

/* test/asp_top_bench.sv */
// Self-checking bench for asp_top driven by the host model.
// Assumes the defines header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "asp_defines.svh"
module asp_top_bench;
   import asp_pkg::*;
   localparam logic [6:0] A_CTL = 7'(`ASP_ADDR_CTL);
   localparam logic [6:0] A_X   = 7'(`ASP_ADDR_ACCX_L);
   logic     clk = 0, rst_n = 0, hold = 1, fault = 0, valid = 0, st = 0, seen = 0;
   asp_acc_t smp_v = '0;
   logic     sclk, cs_n, din, dout, dout_oe, pcm_x, pcm_y, int_rst;
   logic [1:0] hi;
   int       hx;
   int       err_total = 0, comparisons = 0, cycles = 0;
   wire      dout_pin = dout_oe ? dout : 1'bz;
   always #20 clk = ~clk;
   asp_top #(.RST_HOLD_CYC(20)) i_dut (.CORE_CLK_IN(clk), .RSTN_IN(rst_n), .SCLK_IN(sclk),
      .CS_RESET_N_IN(cs_n), .DIN_IN(din), .CAPTURE_HOLD_N_IN(hold), .OSC_FAULT_IN(fault),
      .SAMPLE_VALID_IN(valid), .SAMPLE_IN(smp_v), .SELFTEST_ACTIVE_IN(st), .DOUT_OUT(dout),
      .DOUT_OE_OUT(dout_oe), .PCM_X_OUT(pcm_x), .PCM_Y_OUT(pcm_y), .INT_RESET_OUT(int_rst));
   asp_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout_pin));
   task test_done;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (int_rst === 1'b1) seen = 1'b1;
      if (cycles == 60000) begin
         err_total++;
         $display("unexpected at %0t: timeout", $time);
         test_done();
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task sample(input logic [10:0] v);
      repeat (4) @(posedge clk);
      smp_v <= '{x: v, y: v};
      valid <= 1'b1;
      @(posedge clk) valid <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task wr(input logic [6:0] d);
      logic [15:0] r;
      i_host.xfer(i_host.mk(1'b1, A_CTL, d, 1'b0), r);
   endtask
   task rd(input logic [6:0] a, input logic [7:0] e);
      logic [15:0] r;
      i_host.xfer(i_host.mk(1'b0, a, 7'h00, 1'b0), r);
      i_host.xfer(i_host.mk(1'b0, A_CTL, 7'h00, 1'b0), r);
      chk(16'(r[15:8]), 16'(e));
      chk(16'(^r), 16'h0001);
   endtask
   task pcm_scan;
      hi = 2'b00;
      hx = 0;
      repeat (512 * `ASP_PCM_RES_CYC) begin
         @(posedge clk);
         hi = hi | {pcm_x, pcm_y};
         if (pcm_x === 1'b1) hx++;
      end
   endtask
   task t_hold;
      sample(11'h155);
      rd(A_X, 8'h00);
      @(posedge clk) hold <= 1'b0;
      sample(11'h0A5);
      rd(A_X, 8'hA5);
      @(posedge clk) hold <= 1'b1;
      sample(11'h05A);
      rd(A_X, 8'hA5);
      @(posedge clk) hold <= 1'b0;
      sample(11'h05A);
      rd(A_X, 8'h5A);
   endtask
   task t_selftest;
      @(posedge clk) st <= 1'b1;
      wr(7'h00);
      sample(11'h100);
      rd(A_X, 8'h40);
      wr(7'h02);
      sample(11'h100);
      rd(A_X, 8'hC0);
      @(posedge clk) st <= 1'b0;
   endtask
   task t_pcm;
      wr(7'h00);
      pcm_scan();
      chk(16'(hi), 16'h0000);
      wr(7'h10);
      rd(A_CTL, 8'h10);
      sample(11'h3FF);
      pcm_scan();
      chk(16'(hi), 16'h0003);
      chk(16'(hx), 16'(255 * `ASP_PCM_RES_CYC));
      wr(7'h00);
      repeat (50) @(posedge clk);
      pcm_scan();
      chk(16'(hi), 16'h0000);
   endtask
   task t_errors;
      logic [15:0] r;
      i_host.xfer(i_host.mk(1'b0, A_CTL, 7'h00, 1'b1), r);
      i_host.xfer(i_host.mk(1'b0, A_CTL, 7'h00, 1'b0), r);
      chk(r, `ASP_EXC_WORD);
      @(posedge clk) fault <= 1'b1;
      repeat (8) @(posedge clk);
      i_host.xfer(i_host.mk(1'b0, A_CTL, 7'h00, 1'b0), r);
      chk(r, 16'hFFFF);
      @(posedge clk) fault <= 1'b0;
      chk(16'(seen), 16'h0000);
      i_host.hold_reset();
      chk(16'(seen), 16'h0001);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_hold();
      t_selftest();
      t_pcm();
      t_errors();
      test_done();
   end
endmodule
`default_nettype wire
